// ---- hw/mtpd_regs.svh ----
// What this block does
// - Memory type comes from type bits 2:0
// - Extended: bits 7:5 reserved, 4:3 route
// - Extended encoding only for fixed ranges
// - Standard values unless extended enabled
// - Uncached: no cache, combine, speculation
// - Combining: uncached, combine, speculative reads
// - Write-through: read alloc, write hits update both
// - Protect: read alloc, write hit invalidates
// - Write-back: read alloc, write miss modified
// - Range typing off gives uncached always
`ifndef MTPD_REGS_SVH
`define MTPD_REGS_SVH

// Register byte offsets
`define MTPD_CTRL_OFF      12'h000
`define MTPD_TYPE_OFF      12'h004
`define MTPD_POLICY_OFF    12'h008
`define MTPD_RAW_OFF       12'h00c

// Control register fields
`define MTPD_CTRL_RANGE_EN 0
`define MTPD_CTRL_EXT_EN   1
`define MTPD_CTRL_FIXED    2
`define MTPD_CTRL_GCD      3
`define MTPD_CTRL_RESET    32'h0000_0000

// Type field layout
`define MTPD_TYPE_LO       0
`define MTPD_TYPE_HI       2
`define MTPD_WRROUTE_BIT   3
`define MTPD_RDROUTE_BIT   4
`define MTPD_TYPE_RESET    8'h00

// Policy word bit positions
`define MTPD_P_CACHEABLE   0
`define MTPD_P_RD_ALLOC    1
`define MTPD_P_WR_ALLOC    2
`define MTPD_P_WR_THROUGH  3
`define MTPD_P_WH_INVAL    4
`define MTPD_P_COMBINE     5
`define MTPD_P_SPEC_RD     6
`define MTPD_P_SPEC_ANY    7
`define MTPD_P_WM_MODIFIED 8
`define MTPD_P_RD_ROUTE    9
`define MTPD_P_WR_ROUTE    10
`define MTPD_P_RESERVED    11
`define MTPD_P_WIDTH       12

`endif

// ---- hw/mtpd_pkg.sv ----
package mtpd_pkg;
    // Standard type encodings
    typedef enum logic [2:0] {
        MTPD_UNCACHED_TYPE     = 3'h0,
        MTPD_COMBINING_TYPE    = 3'h1,
        MTPD_RSVD2_TYPE        = 3'h2,
        MTPD_RSVD3_TYPE        = 3'h3,
        MTPD_THROUGH_WRITE_TYPE = 3'h4,
        MTPD_PROTECT_TYPE      = 3'h5,
        MTPD_BACK_WRITE_TYPE   = 3'h6,
        MTPD_RSVD7_TYPE        = 3'h7
    } mtpd_type_t;
endpackage

// ---- hw/mtpd_decode.sv ----
`timescale 1ns/1ns
`include "mtpd_regs.svh"
// Pure decode of one type field into a policy word
module mtpd_decode
    import mtpd_pkg::*;
(
    // Inputs
    input  wire logic [7:0]                 type_field,
    input  wire logic                       range_en,
    input  wire logic                       ext_en,
    input  wire logic                       fixed_range,
    input  wire logic                       global_cache_disable,
    // Result
    output logic      [`MTPD_P_WIDTH-1:0]   policy
);
    logic       ext_active;
    mtpd_type_t mtype;

    // Extended bits only count for fixed ranges once enabled
    assign ext_active = ext_en & fixed_range;
    assign mtype = mtpd_type_t'(type_field[`MTPD_TYPE_HI:`MTPD_TYPE_LO]);

    // Policy table; reserved values set only the reserved flag, with no caching
    always_comb begin
        policy = '0;
        if (!range_en) begin
            policy = '0;
        end else begin
            unique case (mtype)
                MTPD_COMBINING_TYPE: begin
                    policy[`MTPD_P_COMBINE] = 1'b1;
                    policy[`MTPD_P_SPEC_RD] = 1'b1;
                end
                MTPD_THROUGH_WRITE_TYPE: begin
                    policy[`MTPD_P_CACHEABLE]  = 1'b1;
                    policy[`MTPD_P_RD_ALLOC]   = 1'b1;
                    policy[`MTPD_P_WR_THROUGH] = 1'b1;
                    policy[`MTPD_P_SPEC_RD]    = 1'b1;
                    policy[`MTPD_P_SPEC_ANY]   = 1'b1;
                end
                MTPD_PROTECT_TYPE: begin
                    policy[`MTPD_P_CACHEABLE]  = 1'b1;
                    policy[`MTPD_P_RD_ALLOC]   = 1'b1;
                    policy[`MTPD_P_WR_THROUGH] = 1'b1;
                    policy[`MTPD_P_WH_INVAL]   = 1'b1;
                    policy[`MTPD_P_SPEC_RD]    = 1'b1;
                    policy[`MTPD_P_SPEC_ANY]   = 1'b1;
                end
                MTPD_BACK_WRITE_TYPE: begin
                    policy[`MTPD_P_CACHEABLE]   = 1'b1;
                    policy[`MTPD_P_RD_ALLOC]    = 1'b1;
                    policy[`MTPD_P_WR_ALLOC]    = 1'b1;
                    policy[`MTPD_P_WM_MODIFIED] = 1'b1;
                    policy[`MTPD_P_SPEC_RD]     = 1'b1;
                    policy[`MTPD_P_SPEC_ANY]    = 1'b1;
                end
                MTPD_RSVD2_TYPE, MTPD_RSVD3_TYPE, MTPD_RSVD7_TYPE: begin
                    policy[`MTPD_P_RESERVED] = 1'b1;
                end
                MTPD_UNCACHED_TYPE: begin
                    policy = '0;
                end
            endcase
            // Global disable clears cacheable and allocation, keeps the other type flags
            if (global_cache_disable) begin
                policy[`MTPD_P_CACHEABLE] = 1'b0;
                policy[`MTPD_P_RD_ALLOC]  = 1'b0;
                policy[`MTPD_P_WR_ALLOC]  = 1'b0;
            end
            // Routing bits only under the extended encoding
            if (ext_active) begin
                policy[`MTPD_P_RD_ROUTE] = type_field[`MTPD_RDROUTE_BIT];
                policy[`MTPD_P_WR_ROUTE] = type_field[`MTPD_WRROUTE_BIT];
            end
        end
    end
endmodule

// ---- hw/mtpd_top.sv ----
`timescale 1ns/1ns
`include "mtpd_regs.svh"
// APB wrapper: control and type registers feed the decoder
module mtpd_top
    import mtpd_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic      [31:0]              prdata,
    output logic                          pslverr,
    // Direct type field from the range logic
    input  wire logic [7:0]               range_type_field,
    input  wire logic                     range_fixed,
    input  wire logic                     range_valid,
    // Decoded policy to the cache controller
    output logic      [`MTPD_P_WIDTH-1:0] policy_q,
    output logic                          policy_valid_q
);
    logic [3:0]               ctrl_q;
    logic [7:0]               swtype_q;
    logic [`MTPD_P_WIDTH-1:0] live_policy;
    logic [`MTPD_P_WIDTH-1:0] sw_policy;
    logic                     acc;
    logic                     wr;
    logic                     hit;
    logic [31:0]              rd_word;
    logic [31:0]              prdata_q;

    // Zero-wait slave; unmapped offsets answer with an error
    assign acc    = psel & penable;
    assign wr     = acc & pwrite;
    assign pready = 1'b1;
    assign hit    = (paddr == `MTPD_CTRL_OFF) | (paddr == `MTPD_TYPE_OFF) |
                    (paddr == `MTPD_POLICY_OFF) | (paddr == `MTPD_RAW_OFF);
    assign pslverr = acc & ~hit;

    // Control bits: range enable, extended enable, fixed select, cache disable
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_q <= 4'(`MTPD_CTRL_RESET);
        end else if (wr && paddr == `MTPD_CTRL_OFF) begin
            ctrl_q <= pwdata[3:0];
        end
    end

    // Software probe type field
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            swtype_q <= `MTPD_TYPE_RESET;
        end else if (wr && paddr == `MTPD_TYPE_OFF) begin
            swtype_q <= pwdata[7:0];
        end
    end

    // Live path for the pipeline
    mtpd_decode u_live (
        .type_field           (range_type_field),
        .range_en             (ctrl_q[`MTPD_CTRL_RANGE_EN]),
        .ext_en               (ctrl_q[`MTPD_CTRL_EXT_EN]),
        .fixed_range          (range_fixed),
        .global_cache_disable (ctrl_q[`MTPD_CTRL_GCD]),
        .policy               (live_policy)
    );

    // Probe path so software can read back a decode
    mtpd_decode u_probe (
        .type_field           (swtype_q),
        .range_en             (ctrl_q[`MTPD_CTRL_RANGE_EN]),
        .ext_en               (ctrl_q[`MTPD_CTRL_EXT_EN]),
        .fixed_range          (ctrl_q[`MTPD_CTRL_FIXED]),
        .global_cache_disable (ctrl_q[`MTPD_CTRL_GCD]),
        .policy               (sw_policy)
    );

    // Register the live result, one cycle latency
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            policy_q       <= '0;
            policy_valid_q <= 1'b0;
        end else begin
            policy_q       <= range_valid ? live_policy : '0;
            policy_valid_q <= range_valid;
        end
    end

    // Read mux, decoded from the address of the pending transfer
    always_comb begin
        unique case (paddr)
            `MTPD_CTRL_OFF:   rd_word = {28'h0000000, ctrl_q};
            `MTPD_TYPE_OFF:   rd_word = {24'h000000, swtype_q};
            `MTPD_POLICY_OFF: rd_word = {20'h00000, sw_policy};
            `MTPD_RAW_OFF:    rd_word = {20'h00000, policy_q};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // Read data is taken in the setup cycle so it stands from a flop for
    // the whole zero-wait access phase; a live word read is one cycle old
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_word;
        end
    end
    assign prdata = prdata_q;
endmodule

// ---- testbench/mtpd_cache_model.sv ----
`timescale 1ns/1ns
`include "mtpd_regs.svh"
// Cache side: keeps the last valid policy, as the controller would
module mtpd_cache_model (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    // Policy from the decoder
    input  wire logic [`MTPD_P_WIDTH-1:0] policy_q,
    input  wire logic                     policy_valid_q,
    output logic      [`MTPD_P_WIDTH-1:0] used_q
);
    // Stale policy would leak caching, so only valid words are taken
    always_ff @(posedge clk_sys) begin
        if (!rst_n) used_q <= '0;
        else if (policy_valid_q) used_q <= policy_q;
    end
endmodule

// ---- testbench/mtpd_monitor.sv ----
`timescale 1ns/1ns
module mtpd_monitor (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  range_type_field,
    input wire logic        range_valid,
    input wire logic [11:0] policy_q
);
    logic [3:0] ctl_q;
    logic       on;
    logic [2:0] ty;
    // Shadow of the control word, taken at each completed write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) ctl_q <= 4'h0;
        else if (psel && penable && pwrite && pready && paddr == 12'h000) ctl_q <= pwdata[3:0];
    end
    // Decode active with the global disable clear
    assign on = ctl_q[0] & ~ctl_q[3] & range_valid;
    assign ty = range_type_field[2:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    zero_wait_a: assert property (psel && penable |-> pready) else $error("no ready");
    unmapped_err_a: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
        else $error("no slave error");
    range_off_a: assert property (!ctl_q[0] [*2] |-> policy_q == 12'h000)
        else $error("policy while range off");
    uncached_type_a: assert property ($past(on) && $past(ty) == 3'h0 |-> policy_q[7:5] == 3'h0
        && !policy_q[0]) else $error("uncached policy");
    combining_type_a: assert property ($past(on) && $past(ty) == 3'h1 |-> !policy_q[0]
        && policy_q[6:5] == 2'h3) else $error("combining policy");
    through_write_a: assert property ($past(on) && $past(ty) == 3'h4 |-> policy_q[3:0] == 4'hb)
        else $error("write-through policy");
    protect_type_a: assert property ($past(on) && $past(ty) == 3'h5 |-> policy_q[4]
        && policy_q[2:0] == 3'h3) else $error("protect policy");
    back_write_a: assert property ($past(on) && $past(ty) == 3'h6 |-> policy_q[8]
        && policy_q[2:0] == 3'h7) else $error("write-back policy");
    reserved_type_a: assert property ($past(on) && $past(ty) inside {3'h2, 3'h3, 3'h7}
        |-> policy_q[11] && !policy_q[0]) else $error("reserved type policy");
endmodule
bind mtpd_top mtpd_monitor i_mtpd_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .range_type_field(range_type_field), .range_valid(range_valid),
    .policy_q(policy_q));

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0, pol, used;
    logic [31:0] pwdata = 0, prdata, r;
    logic [7:0] fld = 0;
    logic fix = 0, vld = 1, e, pv;
    int num_errors = 0, n_compared = 0;
    logic [11:0] ex [8] = '{12'h000, 12'h060, 12'h800, 12'h800, 12'h00b, 12'h013, 12'h107, 12'h800};
    logic [11:0] mk [8] = '{12'h0e7, 12'h061, 12'h8e1, 12'h8e1, 12'h00f, 12'h017, 12'h11f, 12'h8e1};
    // Clock at 250 MHz
    always #2 clk_sys = ~clk_sys;
    mtpd_top i_mtpd_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .range_type_field(fld), .range_fixed(fix), .range_valid(vld),
        .policy_q(pol), .policy_valid_q(pv));
    mtpd_cache_model i_mtpd_cache_model (.clk_sys(clk_sys), .rst_n(rst_n), .policy_q(pol),
        .policy_valid_q(pv), .used_q(used));
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One APB transfer; holds everything until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Extra edges let the policy reach the cache model too
    task pol_chk(input logic [7:0] f, input logic fx, input logic [11:0] x, input logic [11:0] m);
        fld <= f; fix <= fx;
        repeat (3) @(posedge clk_sys);
        #1 chk("policy", x, pol & m);
        chk("cache policy", x, used & m);
        @(posedge clk_sys);
    endtask
    task t_apb;
        apb(1, 12'h000, 32'h1); apb(0, 12'h000, 0); chk("ctrl", 32'h1, r);
        apb(0, 12'h010, 0); chk("unmapped err", 1, e); chk("unmapped data", 0, r);
        $display("done apb");
    endtask
    task t_std;
        for (int t = 0; t < 8; t++) pol_chk(8'(t), 0, ex[t], mk[t]);
        $display("done standard");
    endtask
    task t_ext;
        apb(1, 12'h000, 32'h3);
        pol_chk(8'hfe, 1, 12'h607, 12'h607);
        pol_chk(8'hfe, 0, 12'h007, 12'h607);
        apb(1, 12'h000, 32'h1);
        pol_chk(8'hfe, 1, 12'h007, 12'h607);
        $display("done extended");
    endtask
    // Probe path with fixed select, global disable, raw readback, valid gating
    task t_probe;
        apb(1, 12'h004, 32'h1e);
        apb(1, 12'h000, 32'h7);
        apb(0, 12'h008, 0);
        chk("probe policy", 32'h7c7, r);
        apb(1, 12'h000, 32'hf);
        apb(0, 12'h008, 0);
        chk("probe disabled", 32'h7c0, r);
        pol_chk(8'h06, 0, 12'h1c0, 12'hfff);
        apb(0, 12'h00c, 0);
        chk("raw policy", 32'h1c0, r);
        apb(0, 12'h000, 0);
        chk("ctrl", 32'hf, r);
        chk("policy valid", 1, pv);
        vld <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("policy valid", 0, pv);
        chk("idle policy", 0, pol);
        chk("cache hold", 12'h1c0, used);
        @(posedge clk_sys);
        vld <= 1'b1;
        $display("done probe");
    endtask
    task t_off;
        apb(1, 12'h000, 32'h0);
        pol_chk(8'h06, 0, 12'h000, 12'hfff);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        apb(0, 12'h004, 0);
        chk("type after reset", 0, r);
        apb(0, 12'h000, 0);
        chk("ctrl after reset", 0, r);
        $display("done range off");
    endtask
    task results;
        $display("checks %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the roughly 110 cycles the tests need
    initial begin
        #100000;
        num_errors++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1;
        @(posedge clk_sys);
        t_apb();
        t_std();
        t_ext();
        t_probe();
        t_off();
        results();
    end
endmodule
